// *** shared/ddr_cmd_pkg.sv ***
package ddr_cmd_pkg;
   localparam int NUM_BANKS = 4;
   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int AUTO_PRECHARGE_BIT = 10;
   localparam int COL_LO_W = 10;
   localparam int COL_HI_BIT = 11;
   localparam int COL_W = 11;
   localparam int BL_LSB = 0;
   localparam int BL_W = 3;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int CL_W = 3;
   localparam int DLL_RST_BIT = 8;
   localparam logic [1:0] MRS_BASE_SEL = 2'h0;
   localparam logic [1:0] MRS_EXT_SEL = 2'h1;
   localparam logic [ADDR_W-1:0] MODE_RESET_VAL = 13'h0000;
   localparam logic [3:0] BANK_OPEN_RESET = 4'h0;
   localparam real INIT_WAIT_US = 200.0;
   localparam real CLK_MHZ = 200.0;
   localparam int INIT_WAIT_CYC = int'(INIT_WAIT_US * CLK_MHZ);
   localparam int DLL_LOCK_CYC = 200;

   typedef enum logic [3:0] {
      CMD_DESEL = 4'h0,
      CMD_NOP = 4'h1,
      CMD_ACT = 4'h2,
      CMD_READ = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_BTERM = 4'h5,
      CMD_PRE = 4'h6,
      CMD_REF = 4'h7,
      CMD_MRS = 4'h8
   } cmd_t;

   typedef enum logic [1:0] {
      PWR_NORMAL = 2'h0,
      PWR_PRE_PD = 2'h1,
      PWR_ACT_PD = 2'h2,
      PWR_SELF_REF = 2'h3
   } pwr_t;
endpackage

// *** shared/ddr_cmd_if.sv ***
`timescale 1ns/1ps
interface ddr_cmd_if;
   import ddr_cmd_pkg::*;
   logic valid;
   cmd_t cmd;
   logic cke_prev;
   logic cke_cur;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   modport decoder (output valid, cmd, cke_prev, cke_cur, bank, addr);
   modport engine (input valid, cmd, cke_prev, cke_cur, bank, addr);
endinterface

// *** rtl/ddr_cmd_decode.sv ***
`timescale 1ns/1ps
module ddr_cmd_decode
   import ddr_cmd_pkg::*;
(
   // link side
   input wire logic link_clk_i,
   input wire logic link_reset_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic cke_i,
   input wire logic [BANK_W-1:0] bank_i,
   input wire logic [ADDR_W-1:0] addr_i,
   // decoded command
   ddr_cmd_if.decoder dec
);
   logic cke_last_r;

   function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                       input logic cas_n, input logic we_n);
      if (cs_n) begin
         decode_cmd = CMD_DESEL;
      end else begin
         unique case ({ras_n, cas_n, we_n})
            3'h7: decode_cmd = CMD_NOP;
            3'h3: decode_cmd = CMD_ACT;
            3'h6: decode_cmd = CMD_BTERM;
            3'h2: decode_cmd = CMD_PRE;
            3'h5: decode_cmd = CMD_READ;
            3'h4: decode_cmd = CMD_WRITE;
            3'h1: decode_cmd = CMD_REF;
            3'h0: decode_cmd = CMD_MRS;
         endcase
      end
   endfunction

   // commands registered on the rising link clock edge
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         dec.valid <= 1'b0;
         dec.cmd <= CMD_DESEL;
         dec.bank <= '0;
         dec.addr <= '0;
         dec.cke_cur <= 1'b0;
         dec.cke_prev <= 1'b0;
         cke_last_r <= 1'b0;
      end else begin
         dec.valid <= 1'b1;
         dec.cmd <= decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
         dec.bank <= bank_i;
         dec.addr <= addr_i;
         dec.cke_cur <= cke_i;
         dec.cke_prev <= cke_last_r;
         cke_last_r <= cke_i;
      end
   end
endmodule

// *** rtl/ddr_cmd_engine.sv ***
`timescale 1ns/1ps
// Behaviour
// - commands sampled on rising link clock
// - deselect, nop, activate, terminate, precharge decoded
// - read, write, refresh, mode set decoded
// - deselect and nop do nothing
// - A10 selects auto precharge per command
// - precharge closes one bank or all
// - refresh command: auto or self refresh
// - bank bits pick mode register target
// - high mask inhibits element write
// - activate latches row, access latches column
// - clock enable edges choose power transitions
// - falling enable enters power-down or self refresh
// - one double word core, two pin words
// - mode registers programmed during init
// - bank 0 base, bank 1 extended register
// - base opcode word passed out whole, fields not decoded
module ddr_cmd_engine
   import ddr_cmd_pkg::*;
#(
   parameter int DQ_W = 8,
   parameter bit WIDE_COL = 1'b1,
   parameter int INIT_WAIT = INIT_WAIT_CYC
)(
   // system clock
   input wire logic clk_i,
   input wire logic reset_i,
   // link pins
   input wire logic link_clk_i,
   input wire logic link_reset_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic cke_i,
   input wire logic [BANK_W-1:0] bank_i,
   input wire logic [ADDR_W-1:0] addr_i,
   // write data, rising and falling element
   input wire logic [DQ_W-1:0] wdata_rise_i,
   input wire logic [DQ_W-1:0] wdata_fall_i,
   input wire logic write_mask_rise_i,
   input wire logic write_mask_fall_i,
   // core side
   output logic [2*DQ_W-1:0] core_wdata_o,
   output logic [1:0] core_wen_o,
   output logic core_wstb_o,
   output logic [NUM_BANKS-1:0] bank_open_o,
   output logic [ADDR_W-1:0] mode_reg_o,
   output logic [ADDR_W-1:0] ext_mode_reg_o,
   output logic [1:0] power_state_o,
   output logic auto_refresh_o,
   output logic illegal_o,
   output logic [COL_W-1:0] col_o,
   output logic [BANK_W-1:0] col_bank_o,
   output logic auto_precharge_o,
   output logic init_done_o
);
   ddr_cmd_if eng ();

   ddr_cmd_decode u_dec (
      .link_clk_i(link_clk_i),
      .link_reset_i(link_reset_i),
      .cs_n_i(cs_n_i),
      .ras_n_i(ras_n_i),
      .cas_n_i(cas_n_i),
      .we_n_i(we_n_i),
      .cke_i(cke_i),
      .bank_i(bank_i),
      .addr_i(addr_i),
      .dec(eng.decoder)
   );

   pwr_t pwr_r;
   logic [NUM_BANKS-1:0] open_r;
   logic [ADDR_W-1:0] row_r [NUM_BANKS];
   logic [ADDR_W-1:0] mr_r;
   logic [ADDR_W-1:0] emr_r;
   logic illegal_r;
   logic aref_r;
   logic [COL_W-1:0] col_r;
   logic [BANK_W-1:0] cbank_r;
   logic auto_precharge_bit_r;
   logic upd_tgl_r;
   logic mr_set_r;
   logic emr_set_r;
   logic any_open;
   logic is_idle_cmd;
   logic cmd_legal;
   logic cke_fall;
   logic cke_rise;
   logic cke_low;
   logic pd_entry;
   logic sr_entry;

   assign any_open = |open_r;
   assign is_idle_cmd = (eng.cmd == CMD_NOP) || (eng.cmd == CMD_DESEL);
   assign cke_fall = eng.cke_prev && !eng.cke_cur;
   assign cke_rise = !eng.cke_prev && eng.cke_cur;
   assign cke_low = !eng.cke_prev && !eng.cke_cur;
   assign pd_entry = cke_fall && is_idle_cmd && (pwr_r == PWR_NORMAL);
   assign sr_entry = cke_fall && (eng.cmd == CMD_REF) && !any_open
                     && (pwr_r == PWR_NORMAL);

   // legality of the current command against the enable history
   always_comb begin
      cmd_legal = 1'b0;
      if (pwr_r != PWR_NORMAL) begin
         cmd_legal = cke_low || (cke_rise && is_idle_cmd);
      end else if (cke_fall) begin
         cmd_legal = is_idle_cmd || sr_entry;
      end else if (eng.cke_prev && eng.cke_cur) begin
         unique case (eng.cmd)
            CMD_DESEL, CMD_NOP, CMD_BTERM, CMD_PRE: cmd_legal = 1'b1;
            CMD_ACT: cmd_legal = !open_r[eng.bank];
            CMD_READ, CMD_WRITE: cmd_legal = open_r[eng.bank];
            CMD_REF: cmd_legal = !any_open;
            CMD_MRS: cmd_legal = !any_open && !eng.bank[1];
            default: cmd_legal = 1'b0;
         endcase
      end
   end

   // power state
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         pwr_r <= PWR_NORMAL;
      end else if (eng.valid && cmd_legal) begin
         if (sr_entry) begin
            pwr_r <= PWR_SELF_REF;
         end else if (pd_entry) begin
            pwr_r <= any_open ? PWR_ACT_PD : PWR_PRE_PD;
         end else if (pwr_r != PWR_NORMAL && cke_rise) begin
            pwr_r <= PWR_NORMAL;
         end
      end
   end

   // bank tracking
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         open_r <= BANK_OPEN_RESET;
      end else if (eng.valid && cmd_legal && eng.cke_cur) begin
         unique case (eng.cmd)
            CMD_ACT: open_r[eng.bank] <= 1'b1;
            CMD_PRE: begin
               if (eng.addr[AUTO_PRECHARGE_BIT]) begin
                  open_r <= '0;
               end else begin
                  open_r[eng.bank] <= 1'b0;
               end
            end
            CMD_READ, CMD_WRITE: begin
               if (eng.addr[AUTO_PRECHARGE_BIT]) begin
                  open_r[eng.bank] <= 1'b0;
               end
            end
            default: open_r <= open_r;
         endcase
      end
   end

   // row latch
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         for (int i = 0; i < NUM_BANKS; i++) begin
            row_r[i] <= '0;
         end
      end else if (eng.valid && cmd_legal && eng.cke_cur && eng.cmd == CMD_ACT) begin
         row_r[eng.bank] <= eng.addr;
      end
   end

   // column latch and auto precharge
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         col_r <= '0;
         cbank_r <= '0;
         auto_precharge_bit_r <= 1'b0;
      end else if (eng.valid && cmd_legal && eng.cke_cur
                   && (eng.cmd == CMD_READ || eng.cmd == CMD_WRITE)) begin
         col_r <= {WIDE_COL & eng.addr[COL_HI_BIT], eng.addr[COL_LO_W-1:0]};
         cbank_r <= eng.bank;
         auto_precharge_bit_r <= eng.addr[AUTO_PRECHARGE_BIT];
      end
   end

   // mode registers
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         mr_r <= MODE_RESET_VAL;
         emr_r <= MODE_RESET_VAL;
         mr_set_r <= 1'b0;
         emr_set_r <= 1'b0;
      end else if (eng.valid && cmd_legal && eng.cke_cur && eng.cmd == CMD_MRS) begin
         if (eng.bank == MRS_BASE_SEL) begin
            mr_r <= eng.addr;
            mr_set_r <= 1'b1;
         end else if (eng.bank == MRS_EXT_SEL) begin
            emr_r <= eng.addr;
            emr_set_r <= 1'b1;
         end
      end
   end

   // flags
   always_ff @(posedge link_clk_i) begin
      if (link_reset_i) begin
         illegal_r <= 1'b0;
         aref_r <= 1'b0;
         upd_tgl_r <= 1'b0;
      end else begin
         illegal_r <= eng.valid && !cmd_legal;
         aref_r <= eng.valid && cmd_legal && eng.cke_prev && eng.cke_cur
                   && eng.cmd == CMD_REF;
         upd_tgl_r <= upd_tgl_r ^ (eng.valid && cmd_legal
                   && (eng.cke_prev != eng.cke_cur || !is_idle_cmd));
      end
   end

   // write path: two pin words form one core word
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         core_wdata_o <= '0;
         core_wen_o <= 2'h0;
         core_wstb_o <= 1'b0;
      end else begin
         core_wdata_o <= {wdata_fall_i, wdata_rise_i};
         core_wen_o <= {!write_mask_fall_i, !write_mask_rise_i};
         core_wstb_o <= !(write_mask_fall_i && write_mask_rise_i);
      end
   end

   // flags and the update toggle, level synchronised
   logic [3:0] lvl_s1_r, lvl_s2_r;
   logic upd_s3_r;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         lvl_s1_r <= 4'h0;
         lvl_s2_r <= 4'h0;
         upd_s3_r <= 1'b0;
      end else begin
         lvl_s1_r <= {mr_set_r & emr_set_r, illegal_r, aref_r, upd_tgl_r};
         lvl_s2_r <= lvl_s1_r;
         upd_s3_r <= lvl_s2_r[0];
      end
   end

   // words are settled once the synced toggle moves; closer commands merge
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         bank_open_o <= BANK_OPEN_RESET;
         auto_precharge_o <= 1'b0;
         power_state_o <= PWR_NORMAL;
         mode_reg_o <= MODE_RESET_VAL;
         ext_mode_reg_o <= MODE_RESET_VAL;
         col_o <= '0;
         col_bank_o <= '0;
      end else if (lvl_s2_r[0] != upd_s3_r) begin
         bank_open_o <= open_r;
         auto_precharge_o <= auto_precharge_bit_r;
         power_state_o <= pwr_r;
         mode_reg_o <= mr_r;
         ext_mode_reg_o <= emr_r;
         col_o <= col_r;
         col_bank_o <= cbank_r;
      end
   end

   assign auto_refresh_o = lvl_s2_r[1];
   assign illegal_o = lvl_s2_r[2];
   assign init_done_o = lvl_s2_r[3];

   precharge_close_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && cmd_legal && eng.cke_cur && eng.cmd == CMD_PRE
      && eng.addr[AUTO_PRECHARGE_BIT]
      |=> open_r == 4'h0) else $error("precharge all left a bank open");
   activate_opens_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && cmd_legal && eng.cke_cur && eng.cmd == CMD_ACT
      |=> open_r[$past(eng.bank)]) else $error("activate did not open bank");
   nop_no_change_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && is_idle_cmd && eng.cke_prev && eng.cke_cur
      |=> $stable(open_r) && $stable(mr_r)) else $error("nop changed state");
   illegal_hold_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && !cmd_legal |=> illegal_r && $stable(open_r))
      else $error("illegal command changed banks");
   self_ref_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && sr_entry |=> pwr_r == PWR_SELF_REF)
      else $error("self refresh not entered");
   pd_type_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && pd_entry && !sr_entry |=> pwr_r == ($past(any_open) ? PWR_ACT_PD : PWR_PRE_PD))
      else $error("wrong power-down type");
   mrs_target_a: assert property (@(posedge link_clk_i) disable iff (link_reset_i)
      eng.valid && cmd_legal && eng.cke_cur && eng.cmd == CMD_MRS && eng.bank == MRS_EXT_SEL
      |=> emr_r == $past(eng.addr) && $stable(mr_r))
      else $error("extended mode set misrouted");
   mask_inhibit_a: assert property (@(posedge clk_i) disable iff (reset_i)
      write_mask_rise_i |=> !core_wen_o[0]) else $error("masked element enabled");
endmodule

// *** test/ddr_ctrl_model.sv ***
`timescale 1ns/1ps
module ddr_ctrl_model
   import ddr_cmd_pkg::*;
#(
   parameter int INIT_NOPS = 8
)(
   // link clock
   input wire logic link_clk_i,
   // command pins
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic cke_o,
   output logic [BANK_W-1:0] bank_o,
   output logic [ADDR_W-1:0] addr_o
);
   initial begin
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = 3'h7;
      cke_o = 1'b0;
      bank_o = 2'h0;
      addr_o = 13'h0000;
   end
   // pins move on the falling link edge so the rising edge sees them settled
   task automatic issue(input logic [2:0] rcw, input logic [1:0] ba, input logic [12:0] a,
      input logic cke_v = 1'b1);
      @(negedge link_clk_i);
      cs_n_o = 1'b0;
      {ras_n_o, cas_n_o, we_n_o} = rcw;
      bank_o = ba;
      addr_o = a;
      cke_o = cke_v;
      @(negedge link_clk_i);
      // deselected pins other than the enable no longer show the last value
      cs_n_o = 1'b1;
      {ras_n_o, cas_n_o, we_n_o} = ~rcw;
      bank_o = ~ba;
      addr_o = ~a;
      repeat (6) @(negedge link_clk_i);
   endtask
   // shortened nop period, enable raised before any command
   task automatic power_up();
      repeat (INIT_NOPS) @(negedge link_clk_i);
      cke_o = 1'b1;
      repeat (2) @(negedge link_clk_i);
   endtask
endmodule

// *** test/ddr_cmd_engine_bench.sv ***
`timescale 1ns/1ps
module ddr_cmd_engine_bench;
   import ddr_cmd_pkg::*;
   localparam logic [2:0] ACT = 3'h3, RD = 3'h5, WR = 3'h4, BT = 3'h6;
   localparam logic [2:0] PRE = 3'h2, REF = 3'h1, MRS = 3'h0, NOP = 3'h7;
   logic clk_i, reset_i, link_clk_i, link_reset_i;
   logic cs_n, ras_n, cas_n, we_n, cke;
   logic [BANK_W-1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wd_r, wd_f;
   logic wm_r, wm_f;
   logic [15:0] core_wdata_o;
   logic [1:0] core_wen_o, power_state_o, col_bank_o, m;
   logic core_wstb_o, auto_refresh_o, illegal_o, auto_precharge_o, init_done_o;
   logic [3:0] bank_open_o;
   logic [12:0] mode_reg_o, ext_mode_reg_o;
   logic [10:0] col_o;
   int errors = 0, tests_run = 0, cycles = 0, ill_cnt = 0, ref_cnt = 0;
   int ill_base, ref_base;

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #1.3;
      forever #3 link_clk_i = ~link_clk_i;
   end

   ddr_ctrl_model #(.INIT_NOPS(8)) u_ctrl (.link_clk_i(link_clk_i), .cs_n_o(cs_n),
      .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .cke_o(cke), .bank_o(bank),
      .addr_o(addr));

   ddr_cmd_engine #(.DQ_W(8), .WIDE_COL(1'b1), .INIT_WAIT(16)) u_dut (.clk_i(clk_i),
      .reset_i(reset_i), .link_clk_i(link_clk_i), .link_reset_i(link_reset_i),
      .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .cke_i(cke),
      .bank_i(bank), .addr_i(addr), .wdata_rise_i(wd_r), .wdata_fall_i(wd_f),
      .write_mask_rise_i(wm_r), .write_mask_fall_i(wm_f), .core_wdata_o(core_wdata_o),
      .core_wen_o(core_wen_o), .core_wstb_o(core_wstb_o), .bank_open_o(bank_open_o),
      .mode_reg_o(mode_reg_o), .ext_mode_reg_o(ext_mode_reg_o),
      .power_state_o(power_state_o), .auto_refresh_o(auto_refresh_o),
      .illegal_o(illegal_o), .col_o(col_o), .col_bank_o(col_bank_o),
      .auto_precharge_o(auto_precharge_o), .init_done_o(init_done_o));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // pulses seen in the system domain are counted
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (illegal_o === 1'b1) ill_cnt <= ill_cnt + 1;
      if (auto_refresh_o === 1'b1) ref_cnt <= ref_cnt + 1;
   end

   initial begin
      fork
         run_tests();
         wait (cycles >= 5000);
      join_any
      if (cycles >= 5000) begin
         errors++;
         $display("[ERR] timeout expected %0d seen %0d", 5000, cycles);
      end
      tally_and_finish();
   end

   task automatic run_tests();
      {wm_r, wm_f} = 2'h0;
      {wd_r, wd_f} = 16'h0000;
      reset_i = 1'b1;
      link_reset_i = 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i) reset_i = 1'b0;
      repeat (2) @(posedge link_clk_i);
      @(negedge link_clk_i) link_reset_i = 1'b0;
      chk("bank_open", 16'h0, 16'(bank_open_o));
      u_ctrl.power_up();
      u_ctrl.issue(PRE, 2'h2, 13'h0400);
      u_ctrl.issue(MRS, MRS_EXT_SEL, 13'h0002);
      chk("ext_mode", 16'h0002, 16'(ext_mode_reg_o));
      u_ctrl.issue(MRS, MRS_BASE_SEL, 13'h0132);
      chk("mode", 16'h0132, 16'(mode_reg_o));
      chk("ext_mode", 16'h0002, 16'(ext_mode_reg_o));
      chk("init_done", 16'h1, 16'(init_done_o));
      repeat (DLL_LOCK_CYC) @(negedge link_clk_i);
      u_ctrl.issue(PRE, 2'h0, 13'h0400);
      ref_base = ref_cnt;
      repeat (2) u_ctrl.issue(REF, 2'h3, 13'h1FFF);
      chk("auto_refresh", 16'h1, 16'(ref_cnt != ref_base));
      u_ctrl.issue(MRS, MRS_BASE_SEL, 13'h0032);
      chk("mode", 16'h0032, 16'(mode_reg_o));
      $display("test init done");
      ill_base = ill_cnt;
      u_ctrl.issue(ACT, 2'h1, 13'h1ABC);
      chk("bank_open", 16'h2, 16'(bank_open_o));
      u_ctrl.issue(NOP, 2'h2, 13'h0000);
      u_ctrl.issue(ACT, 2'h3, 13'h0123);
      chk("bank_open", 16'hA, 16'(bank_open_o));
      u_ctrl.issue(RD, 2'h3, 13'h00A3);
      chk("col", 16'h00A3, 16'(col_o));
      chk("auto_precharge", 16'h0, 16'(auto_precharge_o));
      u_ctrl.issue(BT, 2'h0, 13'h0000);
      u_ctrl.issue(WR, 2'h1, 13'h0D55);
      chk("col", 16'h0555, 16'(col_o));
      chk("col_bank", 16'h1, 16'(col_bank_o));
      chk("auto_precharge", 16'h1, 16'(auto_precharge_o));
      u_ctrl.issue(RD, 2'h3, 13'h0001);
      chk("auto_precharge", 16'h0, 16'(auto_precharge_o));
      chk("illegal", 16'h0, 16'(ill_cnt != ill_base));
      u_ctrl.issue(PRE, 2'h3, 13'h0000);
      chk("bank3_open", 16'h0, 16'(bank_open_o[3]));
      u_ctrl.issue(PRE, 2'h3, 13'h0400);
      chk("bank_open", 16'h0, 16'(bank_open_o));
      u_ctrl.issue(ACT, 2'h0, 13'h0011);
      u_ctrl.issue(ACT, 2'h2, 13'h0022);
      u_ctrl.issue(PRE, 2'h2, 13'h0000);
      chk("bank_open", 16'h1, 16'(bank_open_o));
      $display("test banks done");
      u_ctrl.issue(RD, 2'h2, 13'h0000);
      chk("illegal", 16'h1, 16'(ill_cnt != ill_base));
      chk("bank_open", 16'h1, 16'(bank_open_o));
      ill_base = ill_cnt;
      u_ctrl.issue(MRS, MRS_BASE_SEL, 13'h0021);
      chk("illegal", 16'h1, 16'(ill_cnt != ill_base));
      chk("mode", 16'h0032, 16'(mode_reg_o));
      u_ctrl.issue(PRE, 2'h1, 13'h0400);
      ill_base = ill_cnt;
      u_ctrl.issue(MRS, 2'h2, 13'h0041);
      chk("illegal", 16'h1, 16'(ill_cnt != ill_base));
      chk("ext_mode", 16'h0002, 16'(ext_mode_reg_o));
      $display("test illegal done");
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         @(negedge clk_i);
         wd_r = 8'hA0 + 8'(i);
         wd_f = 8'h50 + 8'(i);
         {wm_f, wm_r} = m;
         @(negedge clk_i);
         chk("core_wen", {14'h0000, ~m}, 16'(core_wen_o));
         chk("core_wstb", 16'(m != 2'h3), 16'(core_wstb_o));
         if (m == 2'h0) chk("core_wdata", {wd_f, wd_r}, core_wdata_o);
      end
      $display("test mask done");
      u_ctrl.issue(NOP, 2'h0, 13'h0000, 1'b0);
      chk("power", 16'h1, 16'(power_state_o));
      u_ctrl.issue(NOP, 2'h0, 13'h0000);
      chk("power", 16'h0, 16'(power_state_o));
      u_ctrl.issue(ACT, 2'h2, 13'h0033);
      u_ctrl.issue(NOP, 2'h0, 13'h0000, 1'b0);
      chk("power", 16'h2, 16'(power_state_o));
      u_ctrl.issue(NOP, 2'h0, 13'h0000);
      u_ctrl.issue(PRE, 2'h0, 13'h0400);
      u_ctrl.issue(REF, 2'h1, 13'h0555, 1'b0);
      chk("power", 16'h3, 16'(power_state_o));
      u_ctrl.issue(NOP, 2'h0, 13'h0000);
      chk("power", 16'h0, 16'(power_state_o));
      $display("test power done");
   endtask
endmodule
